// file: pmic_control_status_regs.sv
// Behaviour
// [RULE1] Enable register: select bit5, enables bits4..0
// [RULE2] Converter enable is register bit OR pin
// [RULE3] Select low gives nominal, high applies codes
// [RULE4] Scaling codes bits3:2 and 1:0, upper unused
// [RULE5] Codes act when select pin or bit high
// [RULE6] Fault flags register read-only, eight fault bits
// [RULE7] Brownout flag set by input comparator
// [RULE8] Reading fault flags clears all of them; the code keeps any flag whose fault condition is still present
// [RULE9] Health register: undervoltage 5:3, power good 2:0
// [RULE10] Health read clears undervoltage bits only
// [RULE11] Alert released once flags read or cleared
// [RULE12] Flags sticky; alert low while any pending
// [RULE13] Four byte addresses; status writes ignored
`timescale 1ns/1ns
`default_nettype none

module pmic_control_status_regs (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Register port from the serial control front end (same clock)
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // External pins and analog comparator levels (asynchronous)
    input wire logic [2:0] CONVERTER_ON_PIN,
    input wire logic SCALING_SELECT_PIN,
    input wire logic [7:0] FAULT_COND,
    input wire logic [2:0] UNDERVOLTAGE_COND,
    input wire logic [2:0] POWER_GOOD_COND,
    // Outputs to the analog rails
    output var pmic_regs_pkg::rail_ctrl_type RAIL_CTRL,
    output logic SCALING_ACTIVE,
    // Open-drain alert: enable low means the pin is pulled low
    output logic ALERT_OUT,
    output logic ALERT_OE_N
);
    // =====================================================================
    // Input synchronisers: three stages, change taken when 2 and 3 agree
    // =====================================================================
    localparam int NSYNC = 18;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    logic [NSYNC-1:0] clean_r;

    assign async_in = {CONVERTER_ON_PIN, SCALING_SELECT_PIN, FAULT_COND,
                       UNDERVOLTAGE_COND, POWER_GOOD_COND};

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            clean_r <= '0;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    clean_r[i] <= s3_r[i];
                end
            end
        end
    end

    logic [2:0] conv_pin;
    logic sel_pin;
    logic [7:0] fault_now;
    logic [2:0] uv_now;
    logic [2:0] pg_now;
    assign {conv_pin, sel_pin, fault_now, uv_now, pg_now} = clean_r;

    // =====================================================================
    // Writable registers
    // =====================================================================
    logic [7:0] enable_r;
    logic [7:0] scaling_r;
    logic wr_en;
    logic wr_scale;

    // Status offsets are not decoded for writes, so those are dropped
    assign wr_en = REG_WR && (REG_ADDR == pmic_regs_pkg::ADDR_RAIL_ENABLE_CONTROL); // see [RULE13]
    assign wr_scale = REG_WR && (REG_ADDR == pmic_regs_pkg::ADDR_OUTPUT_SCALING_LEVELS); // see [RULE13]

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            enable_r <= pmic_regs_pkg::RESET_VALUE; // see [RULE1]
        end else if (wr_en) begin
            enable_r <= REG_WDATA; // see [RULE1]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            scaling_r <= pmic_regs_pkg::RESET_VALUE; // see [RULE4]
        end else if (wr_scale) begin
            // Unused upper bits kept at zero
            scaling_r <= REG_WDATA & pmic_regs_pkg::SCALING_USED_MASK; // see [RULE4]
        end
    end

    // =====================================================================
    // Sticky status flags
    // =====================================================================
    logic rd_fault;
    logic rd_health;
    logic [7:0] fault_flags;
    logic [2:0] uv_flags;

    assign rd_fault = REG_RD && (REG_ADDR == pmic_regs_pkg::ADDR_SUPPLY_FAULT_FLAGS);
    assign rd_health = REG_RD && (REG_ADDR == pmic_regs_pkg::ADDR_CONVERTER_HEALTH_FLAGS);

    // Bit 7 is the input-supply brownout comparator
    sticky_flags #(
        .WIDTH(8)
    ) u_fault (
        .clk(CLOCK),
        .rst(SYS_RST),
        .set_in(fault_now), // see [RULE6] [RULE7]
        .clear(rd_fault), // see [RULE8]
        .flags(fault_flags)
    );

    sticky_flags #(
        .WIDTH(3)
    ) u_uv (
        .clk(CLOCK),
        .rst(SYS_RST),
        .set_in(uv_now),
        .clear(rd_health), // see [RULE10]
        .flags(uv_flags)
    );

    // =====================================================================
    // Read path
    // =====================================================================
    logic [7:0] health_word;
    always_comb begin
        health_word = '0;
        health_word[pmic_regs_pkg::UVD_HI:pmic_regs_pkg::UVD_LO] = uv_flags; // see [RULE9]
        // Power good is live, never latched
        health_word[pmic_regs_pkg::PG_HI:pmic_regs_pkg::PG_LO] = pg_now; // see [RULE10]
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            REG_RDATA <= '0;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    pmic_regs_pkg::ADDR_RAIL_ENABLE_CONTROL: REG_RDATA <= enable_r;
                    pmic_regs_pkg::ADDR_OUTPUT_SCALING_LEVELS: REG_RDATA <= scaling_r;
                    pmic_regs_pkg::ADDR_SUPPLY_FAULT_FLAGS: REG_RDATA <= fault_flags; // see [RULE6]
                    pmic_regs_pkg::ADDR_CONVERTER_HEALTH_FLAGS: REG_RDATA <= health_word;
                    default: REG_RDATA <= '0;
                endcase
            end
        end
    end

    // =====================================================================
    // Rail control outputs
    // =====================================================================
    logic scale_on;
    assign scale_on = sel_pin || enable_r[pmic_regs_pkg::BIT_SCALING_SELECT]; // see [RULE5]

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            RAIL_CTRL <= '0;
            SCALING_ACTIVE <= 1'b0;
        end else begin
            RAIL_CTRL.converter1_on <= enable_r[pmic_regs_pkg::BIT_CONVERTER1_ON]
                                       | conv_pin[2]; // see [RULE2]
            RAIL_CTRL.converter2_on <= enable_r[pmic_regs_pkg::BIT_CONVERTER2_ON]
                                       | conv_pin[1]; // see [RULE2]
            RAIL_CTRL.converter3_on <= enable_r[pmic_regs_pkg::BIT_CONVERTER3_ON]
                                       | conv_pin[0]; // see [RULE2]
            RAIL_CTRL.usb_switch1_on <= enable_r[pmic_regs_pkg::BIT_USB_SWITCH1_ON];
            RAIL_CTRL.usb_switch2_on <= enable_r[pmic_regs_pkg::BIT_USB_SWITCH2_ON];
            SCALING_ACTIVE <= scale_on;
            RAIL_CTRL.converter2_scale_code <= scale_on
                ? scaling_r[pmic_regs_pkg::CODE2_HI:pmic_regs_pkg::CODE2_LO]
                : pmic_regs_pkg::SCALE_NOMINAL; // see [RULE3]
            RAIL_CTRL.converter3_scale_code <= scale_on
                ? scaling_r[pmic_regs_pkg::CODE3_HI:pmic_regs_pkg::CODE3_LO]
                : pmic_regs_pkg::SCALE_NOMINAL; // see [RULE3]
        end
    end

    // =====================================================================
    // Alert: pending while any clearable flag is set
    // =====================================================================
    // Reads clear the flags, so the release after reading both registers
    // falls out of the same term with no extra bookkeeping.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ALERT_OE_N <= 1'b1;
        end else begin
            ALERT_OE_N <= !((|fault_flags) || (|uv_flags)); // see [RULE11] [RULE12]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ALERT_OUT <= 1'b0;
        end else begin
            ALERT_OUT <= 1'b0;
        end
    end
endmodule // pmic_control_status_regs

`default_nettype wire

// file: pmic_regs_pkg.sv
`default_nettype none

package pmic_regs_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] ADDR_RAIL_ENABLE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_SCALING_LEVELS = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_FAULT_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_CONVERTER_HEALTH_FLAGS = 8'h03;

    localparam logic [7:0] RESET_VALUE = 8'h00;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int BIT_SCALING_SELECT = 5;
    localparam int BIT_CONVERTER1_ON = 4;
    localparam int BIT_CONVERTER2_ON = 3;
    localparam int BIT_CONVERTER3_ON = 2;
    localparam int BIT_USB_SWITCH1_ON = 1;
    localparam int BIT_USB_SWITCH2_ON = 0;
    localparam int CODE2_HI = 3;
    localparam int CODE2_LO = 2;
    localparam int CODE3_HI = 1;
    localparam int CODE3_LO = 0;
    localparam int UVD_HI = 5;
    localparam int UVD_LO = 3;
    localparam int PG_HI = 2;
    localparam int PG_LO = 0;

    localparam logic [7:0] SCALING_USED_MASK = 8'h0F;
    localparam logic [1:0] SCALE_NOMINAL = 2'h0;

    // =====================================================================
    // Bundled carriers
    // =====================================================================
    typedef struct packed {
        logic brownout;
        logic thermal_shutdown;
        logic thermal_early_warning;
        logic main_input_lockout;
        logic converter_supply_lockout;
        logic usb_supply_lockout;
        logic usb_fault_ch1;
        logic usb_fault_ch2;
    } fault_vec_type;

    typedef struct packed {
        logic converter1_on;
        logic converter2_on;
        logic converter3_on;
        logic usb_switch1_on;
        logic usb_switch2_on;
        logic [1:0] converter2_scale_code;
        logic [1:0] converter3_scale_code;
    } rail_ctrl_type;

endpackage

`default_nettype wire

// file: sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// Sticky flag group: set wins over a clear-on-read in the same cycle
// =====================================================================
module sticky_flags #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic clear,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= '0;
        end else if (clear) begin
            flags_r <= set_in; // see [RULE12]
        end else begin
            flags_r <= flags_r | set_in; // see [RULE12]
        end
    end

    assign flags = flags_r;
endmodule // sticky_flags

`default_nettype wire

// file: pmic_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========
// Host side of the register port
// ==========
module pmic_host_model (
    input wire logic clk,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // Released lines go inverted so stale values cannot pass
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(negedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd <= 1'b1;
        addr <= a;
        @(negedge clk);
        rd <= 1'b0;
        addr <= ~a;
        d = rvalid ? rdata : 8'hXX;
    endtask
endmodule // pmic_host_model

`default_nettype wire

// file: pmic_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none

// ==========
// Port-level checks
// ==========
module pmic_regs_asserts (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic [2:0] CONVERTER_ON_PIN,
    input wire logic SCALING_SELECT_PIN,
    input wire logic [7:0] FAULT_COND,
    input wire logic [2:0] POWER_GOOD_COND,
    input wire pmic_regs_pkg::rail_ctrl_type RAIL_CTRL,
    input wire logic SCALING_ACTIVE,
    input wire logic ALERT_OUT,
    input wire logic ALERT_OE_N
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    property usb_write_p;
        logic [7:0] d;
        (REG_WR && REG_ADDR == 8'h00, d = REG_WDATA) |-> ##2
            RAIL_CTRL.usb_switch1_on == d[1] && RAIL_CTRL.usb_switch2_on == d[0];
    endproperty

    chk_usb_write_applied: assert property (usb_write_p)
        else $error("enable write not applied");
    chk_conv_pin_or: assert property ((CONVERTER_ON_PIN[2])[*8] |-> RAIL_CTRL.converter1_on)
        else $error("converter pin ignored");
    chk_scale_nominal: assert property (!SCALING_ACTIVE |->
        RAIL_CTRL.converter2_scale_code == 2'h0 && RAIL_CTRL.converter3_scale_code == 2'h0)
        else $error("codes applied while inactive");
    chk_scale_pin_on: assert property (SCALING_SELECT_PIN[*8] |-> SCALING_ACTIVE)
        else $error("select pin ignored");
    chk_fault_read_clears: assert property ((FAULT_COND == 8'h00)[*8] ##0
        (REG_RD && REG_ADDR == 8'h02) ##[1:3] (REG_RD && REG_ADDR == 8'h02) |=> REG_RDATA == 8'h00)
        else $error("fault flags not cleared");
    chk_good_stays_live: assert property ((POWER_GOOD_COND[0])[*8] ##0
        (REG_RD && REG_ADDR == 8'h03) |=> REG_RDATA[0])
        else $error("power good lost");
    chk_alert_pending_low: assert property ((FAULT_COND[6])[*8] |-> !ALERT_OE_N)
        else $error("alert not driven");
    chk_alert_data_zero: assert property (ALERT_OUT == 1'b0)
        else $error("alert data not low");
    chk_read_answer_next: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    chk_rvalid_has_cause: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("stray read valid");
    chk_unmapped_reads_zero: assert property (REG_RD && REG_ADDR > 8'h03 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");

    cover property (REG_RD && REG_ADDR == 8'h02);
    cover property ($fell(ALERT_OE_N));
    cover property (REG_WR && REG_ADDR == 8'h01);
endmodule // pmic_regs_asserts

bind pmic_control_status_regs pmic_regs_asserts pmic_regs_asserts_i (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .CONVERTER_ON_PIN(CONVERTER_ON_PIN), .SCALING_SELECT_PIN(SCALING_SELECT_PIN),
    .FAULT_COND(FAULT_COND), .POWER_GOOD_COND(POWER_GOOD_COND), .RAIL_CTRL(RAIL_CTRL),
    .SCALING_ACTIVE(SCALING_ACTIVE), .ALERT_OUT(ALERT_OUT), .ALERT_OE_N(ALERT_OE_N)
);

`default_nettype wire

// file: pmic_control_status_regs_test.sv
`timescale 1ns/1ns
`default_nettype none

module pmic_control_status_regs_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, scaling_active, alert_out, alert_oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] conv_pin = 3'h0;
    logic [2:0] uv_cond = 3'h0;
    logic [2:0] pg_cond = 3'h0;
    logic sel_pin = 1'b0;
    logic [7:0] fault_cond = 8'h00;
    pmic_regs_pkg::rail_ctrl_type rail_ctrl;
    int bad_count = 0;
    int num_checks = 0;

    always #4 clock = ~clock;

    pmic_control_status_regs pmic_control_status_regs_i (
        .CLOCK(clock), .SYS_RST(sys_rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .CONVERTER_ON_PIN(conv_pin), .SCALING_SELECT_PIN(sel_pin),
        .FAULT_COND(fault_cond), .UNDERVOLTAGE_COND(uv_cond), .POWER_GOOD_COND(pg_cond),
        .RAIL_CTRL(rail_ctrl), .SCALING_ACTIVE(scaling_active), .ALERT_OUT(alert_out),
        .ALERT_OE_N(alert_oe_n)
    );

    pmic_host_model pmic_host_model_i (
        .clk(clock), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr), .wdata(reg_wdata),
        .rdata(reg_rdata), .rvalid(reg_rvalid)
    );

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        pmic_host_model_i.rd_reg(a, d);
        check({1'b0, d}, {1'b0, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        summarize();
    end

    initial begin
        idle(3);
        sys_rst = 1'b0;
        for (int a = 0; a < 4; a++) rd(8'(a), 8'h00);
        check({8'h00, alert_oe_n}, 9'h001);
        check({8'h00, scaling_active}, 9'h000);
        $display("reset test done");
        pmic_host_model_i.wr_reg(8'h00, 8'hFF);
        rd(8'h00, 8'hFF);
        check(rail_ctrl, 9'h1F0);
        check({8'h00, scaling_active}, 9'h001);
        pmic_host_model_i.wr_reg(8'h01, 8'hFF);
        rd(8'h01, 8'h0F);
        check(rail_ctrl, 9'h1FF);
        pmic_host_model_i.wr_reg(8'h00, 8'h00);
        idle(2);
        check(rail_ctrl, 9'h000);
        check({8'h00, scaling_active}, 9'h000);
        sel_pin = 1'b1;
        idle(10);
        check(rail_ctrl, 9'h00F);
        check({8'h00, scaling_active}, 9'h001);
        sel_pin = 1'b0;
        for (int i = 0; i < 3; i++) begin
            conv_pin = 3'(1 << i);
            idle(10);
            check(rail_ctrl, 9'(9'h040 << i));
        end
        conv_pin = 3'h0;
        pmic_host_model_i.wr_reg(8'h02, 8'hFF);
        pmic_host_model_i.wr_reg(8'h03, 8'hFF);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h07, 8'h00);
        $display("control test done");
        for (int i = 0; i < 8; i++) begin
            fault_cond = 8'(1 << i);
            idle(10);
            fault_cond = 8'h00;
            idle(10);
            check({8'h00, alert_oe_n}, 9'h000);
            rd(8'h02, 8'(1 << i));
            rd(8'h02, 8'h00);
            check({8'h00, alert_oe_n}, 9'h001);
        end
        $display("fault test done");
        uv_cond = 3'h5;
        pg_cond = 3'h3;
        fault_cond = 8'h80;
        idle(10);
        uv_cond = 3'h0;
        fault_cond = 8'h00;
        idle(10);
        rd(8'h03, 8'h2B);
        rd(8'h03, 8'h03);
        check({8'h00, alert_oe_n}, 9'h000);
        rd(8'h02, 8'h80);
        idle(2);
        check({8'h00, alert_oe_n}, 9'h001);
        $display("health test done");
        summarize();
    end
endmodule // pmic_control_status_regs_test

`default_nettype wire
